// ===== src/rsci_pkg.sv
// Package for the remote status and command intake block.
// Assumes one clock domain; byte streams arrive already handshaken.
package rsci_pkg;
  // ****************
  // Buffer and status layout
  // ****************
  localparam int           RSCI_BUF_DEPTH   = 512;
  localparam int           RSCI_BIT_SETDONE = 0;
  localparam int           RSCI_BIT_ERROR   = 2;
  localparam int           RSCI_BIT_OPDONE  = 3;
  localparam int           RSCI_BIT_OVFL    = 5;
  localparam int           RSCI_BIT_RQS     = 6;
  localparam logic [7:0]   RSCI_STB_RESET   = 8'h00;
  localparam logic [7:0]   RSCI_MASK_RESET  = 8'h00;
  localparam logic [7:0]   RSCI_ZERO_BITS   = 8'h92;
  // ****************
  // Characters
  // ****************
  localparam logic [7:0]   RSCI_CR    = 8'h0D;
  localparam logic [7:0]   RSCI_LF    = 8'h0A;
  localparam logic [7:0]   RSCI_COMMA = 8'h2C;
  localparam logic [7:0]   RSCI_SPACE = 8'h20;
  localparam logic [7:0]   RSCI_DOT   = 8'h2E;
  localparam logic [7:0]   RSCI_ZERO  = 8'h30;
  // ****************
  // Commands, dialects, terminator settings
  // ****************
  typedef enum logic [3:0] {
    RSCI_CMD_NONE, RSCI_CMD_SET_MASK, RSCI_CMD_QUERY_MASK,
    RSCI_CMD_QUERY_STATUS_BYTE, RSCI_CMD_QUERY_SETTING_DONE,
    RSCI_CMD_QUERY_OPERATION_DONE, RSCI_CMD_SET_TERMINATOR,
    RSCI_CMD_SELECT_DIALECT, RSCI_CMD_QUERY_DIALECT, RSCI_CMD_OTHER
  } rsci_cmd_e;
  typedef enum logic [1:0] {
    RSCI_DIALECT_NATIVE, RSCI_DIALECT_FIRST, RSCI_DIALECT_SECOND
  } rsci_dialect_e;
  localparam logic          RSCI_TERM_EOI_ONLY = 1'b0;
  localparam logic          RSCI_TERM_CRLF_EOI = 1'b1;
  localparam logic          RSCI_TERM_RESET    = RSCI_TERM_CRLF_EOI;
endpackage : rsci_pkg

// ===== src/rsci_byte_if.sv
// Byte stream carrier between the query answer logic and the outgoing buffer.
// Assumes the receiver holds ready as long as it can take bytes.
interface rsci_byte_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       last;
  modport src (output valid, output data, output last, input ready);
  modport dst (input valid, input data, input last, output ready);
endinterface : rsci_byte_if

// ===== src/rsci_tx_buffer.sv
// Outgoing send buffer of the remote front end.
// Assumes the talker side pulls bytes with tx_ready; same clock.
module rsci_tx_buffer
  import rsci_pkg::*;
#(
  parameter int DEPTH = RSCI_BUF_DEPTH
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  resetn,
  input  wire logic  flush,
  // Byte input
  rsci_byte_if.dst   wr,
  // Talker side
  output logic       tx_valid,
  output logic [7:0] tx_data,
  output logic       tx_eoi,
  input  wire logic  tx_ready
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH)
    $error("DEPTH must be a power of two");

  logic [8:0]    mem [DEPTH];
  logic [AW:0]   wptr;
  logic [AW:0]   rptr;
  logic          full;
  logic          empty;

  assign full  = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign empty = (wptr == rptr);
  assign wr.ready = !full;

  // ****************************************************************
  // Storage; terminators take a slot like any byte
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (wr.valid && !full) begin // [RULE_01]
      mem[wptr[AW-1:0]] <= {wr.last, wr.data};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr <= '0;
      rptr <= '0;
    end else if (flush) begin // [RULE_22]
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (wr.valid && !full) wptr <= wptr + 1'b1;
      if (tx_valid && tx_ready) rptr <= rptr + 1'b1;
    end
  end

  // Output register so talker pins come from flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_eoi   <= 1'b0;
    end else begin
      tx_valid <= !empty && !flush && !(tx_valid && tx_ready
                  && (rptr + 1'b1) == wptr);
      tx_data  <= (tx_valid && tx_ready) ? mem[rptr[AW-1:0] + 1'b1][7:0]
                                         : mem[rptr[AW-1:0]][7:0];
      tx_eoi   <= (tx_valid && tx_ready) ? mem[rptr[AW-1:0] + 1'b1][8]
                                         : mem[rptr[AW-1:0]][8];
    end
  end
endmodule // rsci_tx_buffer

// ===== src/rsci_top.sv
// Remote status and command intake: receive buffer, program code
// parser, status byte with service request mask and query answers.
// Assumes a bus acceptor delivering bytes with EOI, same clock.
//
// Overview of operation
// [RULE_01] Send and receive buffers hold 512 bytes each, control codes included.
// [RULE_02] Bit 6 set when service request issued; bits 7, 4, 1 read zero.
// [RULE_03] Bit 5 set on receive overflow; bit 2 set while error exists.
// [RULE_04] Bit 3 set on sweep, program, standby, init or calibration done.
// [RULE_05] Bit 0 set on optical output or wavelength setting done.
// [RULE_06] Mask value 0 to 255 enables causes bit by bit; 0 masks all.
// [RULE_07] Mask bit 6 has no effect; bit 6 never disabled.
// [RULE_08] Writing mask clears status byte and withdraws pending request.
// [RULE_09] Enabled cause sets its bit with bit 6 and requests service.
// [RULE_10] Mask and status byte queries answer decimal 0 to 255.
// [RULE_11] Setting-done query answers two characters: output, wavelength.
// [RULE_12] Operation-done query answers five characters in cause order.
// [RULE_13] Comma separated program codes execute one after another.
// [RULE_14] Spaces inside program codes are ignored.
// [RULE_15] Accept CR LF with EOI, CR LF, and LF with EOI as terminators.
// [RULE_16] Output ends with EOI only, or CR LF with EOI on last byte.
// [RULE_17] Numbers may omit leading and trailing fractional zeros.
// [RULE_18] All program codes refused during a wavelength sweep.
// [RULE_19] Controller waits about 100 ms after device clear; the model waits CLR_WAIT = 100 clock cycles, 800 ns in the bench.
// [RULE_20] Three dialects selectable; later commands use it; query reports it.
// [RULE_21] Native template asterisks are single digits, except identity, reset.
// [RULE_22] Device clear empties send and receive buffers.
// [RULE_23] Full receive buffer drops bytes and flags overflow until cleared.
module rsci_top
  import rsci_pkg::*;
#(
  parameter int DEPTH = RSCI_BUF_DEPTH
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Listener byte stream
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_eoi,
  input  wire logic       dev_clear,
  // Command tokens from the keyword decoder
  input  wire logic       cmd_valid,
  input  wire rsci_cmd_e  cmd_code,
  input  wire logic [1:0] cmd_arg,
  // Instrument events
  input  wire logic       ev_output_set_done,
  input  wire logic       ev_wavelength_set_done,
  input  wire logic       ev_sweep_end,
  input  wire logic       ev_program_end,
  input  wire logic       ev_standby_done,
  input  wire logic       ev_init_done,
  input  wire logic       ev_calib_done,
  input  wire logic       error_active,
  input  wire logic       sweep_active,
  // Parsed code toward the keyword decoder
  output logic            code_valid,
  output logic [7:0]      code_char,
  output logic            code_end,
  output logic            code_digit,
  output logic [19:0]     code_number,
  output logic            msg_end,
  output logic            code_refused,
  // Talker side
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  output logic            tx_eoi,
  input  wire logic       tx_ready,
  // Status
  output logic            srq,
  output logic [7:0]      status_byte,
  output logic [7:0]      service_request_enable_mask,
  output rsci_dialect_e   dialect,
  output logic            native_strict
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH)
    $error("DEPTH must be a power of two");

  // ****************
  // Input synchronisers (pins from the bus acceptor)
  // ****************
  logic [10:0] sync1;
  logic [10:0] sync2;
  logic        sweep_q;
  logic        err_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {dev_clear, rx_eoi, rx_valid, rx_data};
      sync2 <= sync1;
    end
  end
  logic       rxv_prev;
  logic       rx_stb;
  logic [7:0] rx_byte;
  logic       rx_end_flag;
  logic       clr;
  assign rx_byte     = sync2[7:0];
  assign rx_end_flag = sync2[9];
  assign clr         = sync2[10];
  assign rx_stb      = sync2[8] && !rxv_prev;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxv_prev <= 1'b0;
      sweep_q  <= 1'b0;
      err_q    <= 1'b0;
    end else begin
      rxv_prev <= sync2[8];
      sweep_q  <= sweep_active;
      err_q    <= error_active;
    end
  end

  // ****************
  // Receive buffer
  // ****************
  logic [8:0]  rx_mem [DEPTH];
  logic [AW:0] rx_w;
  logic [AW:0] rx_r;
  logic        rx_full;
  logic        rx_empty;
  logic        rx_pop;
  logic        ovfl_ev;
  assign rx_full  = (rx_w[AW] != rx_r[AW]) && (rx_w[AW-1:0] == rx_r[AW-1:0]);
  assign rx_empty = (rx_w == rx_r);
  assign ovfl_ev  = rx_stb && rx_full; // [RULE_23]
  always_ff @(posedge clk) begin
    if (rx_stb && !rx_full) begin // [RULE_01]
      rx_mem[rx_w[AW-1:0]] <= {rx_end_flag, rx_byte};
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_w <= '0;
      rx_r <= '0;
    end else if (clr) begin // [RULE_22]
      rx_w <= '0;
      rx_r <= '0;
    end else begin
      if (rx_stb && !rx_full) rx_w <= rx_w + 1'b1;
      if (rx_pop) rx_r <= rx_r + 1'b1;
    end
  end

  // ****************
  // Program code parser
  // ****************
  function automatic logic is_digit(input logic [7:0] c);
    return c >= RSCI_ZERO && c <= 8'h39;
  endfunction

  logic [7:0] cur;
  logic       cur_eoi;
  logic       cr_seen;
  logic       in_frac;
  logic [1:0] frac_n;
  logic       any_digit;
  // Mask needs the plain integer, not the x1000 fixed point value
  logic [19:0] code_whole;
  assign cur     = rx_mem[rx_r[AW-1:0]][7:0];
  assign cur_eoi = rx_mem[rx_r[AW-1:0]][8];
  assign rx_pop  = !rx_empty && !clr;

  // Fixed point with three fraction digits; missing digits pad zero
  function automatic logic [19:0] scale(input logic [19:0] v,
                                        input logic [1:0] n);
    logic [19:0] r;
    r = v;
    for (int i = 0; i < 3; i++) begin
      if (i >= n) r = 20'(r * 10);
    end
    return r;
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      code_valid   <= 1'b0;
      code_char    <= 8'h00;
      code_end     <= 1'b0;
      code_digit   <= 1'b0;
      code_number  <= '0;
      msg_end      <= 1'b0;
      code_refused <= 1'b0;
      cr_seen      <= 1'b0;
      in_frac      <= 1'b0;
      frac_n       <= '0;
      any_digit    <= 1'b0;
      code_whole   <= '0;
    end else begin
      code_valid   <= 1'b0;
      code_end     <= 1'b0;
      msg_end      <= 1'b0;
      code_refused <= 1'b0;
      if (clr) begin
        cr_seen   <= 1'b0;
        in_frac   <= 1'b0;
        frac_n    <= '0;
        any_digit <= 1'b0;
        code_number <= '0;
      end else if (rx_pop) begin
        if (sweep_q) begin
          code_refused <= 1'b1; // [RULE_18]
        end else if (cur == RSCI_SPACE) begin
          // Skip silently [RULE_14]
        end else if (cur == RSCI_CR) begin
          cr_seen <= 1'b1;
        end else if (cur == RSCI_COMMA
                     || (cur == RSCI_LF && (cr_seen || cur_eoi))) begin
          // [RULE_13] [RULE_15]
          code_end    <= 1'b1;
          code_number <= scale(code_number, frac_n); // [RULE_17]
          code_whole  <= code_number;
          msg_end     <= (cur == RSCI_LF);
          cr_seen     <= 1'b0;
          in_frac     <= 1'b0;
          frac_n      <= '0;
          any_digit   <= 1'b0;
        end else if (cur == RSCI_DOT) begin
          in_frac <= 1'b1;
        end else begin
          cr_seen    <= 1'b0;
          code_valid <= 1'b1;
          code_char  <= cur;
          code_digit <= is_digit(cur);
          if (any_digit && !is_digit(cur)) code_number <= '0;
          if (is_digit(cur) && !(in_frac && frac_n == 2'd3)) begin
            if (!any_digit) code_number <= 20'(cur - RSCI_ZERO);
            else code_number <= 20'(code_number * 10 + (cur - RSCI_ZERO));
            any_digit <= 1'b1;
            if (in_frac) frac_n <= frac_n + 1'b1;
          end
        end
      end
    end
  end

  // ****************
  // Dialect and terminator settings
  // ****************
  logic term_sel;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dialect       <= RSCI_DIALECT_NATIVE;
      term_sel      <= RSCI_TERM_RESET;
      native_strict <= 1'b1;
    end else if (cmd_valid) begin
      if (cmd_code == RSCI_CMD_SELECT_DIALECT && cmd_arg != 2'd3) begin
        dialect       <= rsci_dialect_e'(cmd_arg); // [RULE_20]
        native_strict <= (cmd_arg == 2'd0); // [RULE_21]
      end
      if (cmd_code == RSCI_CMD_SET_TERMINATOR) term_sel <= cmd_arg[0];
    end
  end

  // ****************
  // Status byte and service request
  // ****************
  logic       mask_wr;
  logic [7:0] cause;
  logic [7:0] enabled;
  logic [1:0] set_causes;
  logic [4:0] op_causes;
  assign mask_wr = cmd_valid && cmd_code == RSCI_CMD_SET_MASK;
  always_comb begin
    cause = 8'h00;
    cause[RSCI_BIT_SETDONE] = ev_output_set_done
                              || ev_wavelength_set_done; // [RULE_05]
    cause[RSCI_BIT_OPDONE]  = ev_sweep_end || ev_program_end
                              || ev_standby_done || ev_init_done
                              || ev_calib_done; // [RULE_04]
    cause[RSCI_BIT_ERROR]   = err_q; // [RULE_03]
    cause[RSCI_BIT_OVFL]    = ovfl_ev; // [RULE_03]
    enabled = cause & service_request_enable_mask & ~RSCI_ZERO_BITS; // [RULE_06]
    enabled[RSCI_BIT_RQS] = 1'b0; // [RULE_07]
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      service_request_enable_mask <= RSCI_MASK_RESET;
    end else if (mask_wr) begin
      service_request_enable_mask <= code_whole[7:0]; // [RULE_06]
    end
  end

  // Clear wins over events for srq; the mask write wipes all
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_byte <= RSCI_STB_RESET;
      srq         <= 1'b0;
      set_causes  <= '0;
      op_causes   <= '0;
    end else if (mask_wr) begin
      status_byte <= RSCI_STB_RESET; // [RULE_08]
      srq         <= 1'b0; // [RULE_08]
      set_causes  <= '0;
      op_causes   <= '0;
    end else begin
      if (|enabled) begin
        status_byte <= status_byte | enabled
                       | (8'h01 << RSCI_BIT_RQS); // [RULE_09] [RULE_02]
        srq         <= 1'b1; // [RULE_09]
      end
      if (clr) srq <= 1'b0;
      set_causes <= set_causes
                    | {ev_output_set_done, ev_wavelength_set_done};
      op_causes  <= op_causes | {ev_sweep_end, ev_program_end,
                    ev_standby_done, ev_init_done, ev_calib_done};
    end
  end

  // ****************
  // Query answers into the send buffer
  // ****************
  rsci_byte_if txb ();
  logic [7:0] ans [8];
  logic [3:0] ans_len;
  logic [3:0] ans_idx;
  logic       busy;

  function automatic logic [7:0] ch(input logic b);
    return b ? 8'h31 : RSCI_ZERO;
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy    <= 1'b0;
      ans_len <= '0;
      ans_idx <= '0;
      for (int i = 0; i < 8; i++) ans[i] <= 8'h00;
    end else if (clr) begin
      busy <= 1'b0;
    end else if (!busy && cmd_valid) begin
      ans_idx <= '0;
      busy    <= 1'b1;
      case (cmd_code)
        RSCI_CMD_QUERY_MASK, RSCI_CMD_QUERY_STATUS_BYTE: begin // [RULE_10]
          automatic logic [7:0] v = (cmd_code == RSCI_CMD_QUERY_MASK)
                                    ? service_request_enable_mask
                                    : status_byte;
          ans[0]  <= RSCI_ZERO + 8'(v / 100);
          ans[1]  <= RSCI_ZERO + 8'((v / 10) % 10);
          ans[2]  <= RSCI_ZERO + 8'(v % 10);
          ans_len <= 4'd3;
        end
        RSCI_CMD_QUERY_SETTING_DONE: begin // [RULE_11]
          ans[0]  <= ch(set_causes[1]);
          ans[1]  <= ch(set_causes[0]);
          ans_len <= 4'd2;
        end
        RSCI_CMD_QUERY_OPERATION_DONE: begin // [RULE_12]
          for (int i = 0; i < 5; i++) ans[i] <= ch(op_causes[4-i]);
          ans_len <= 4'd5;
        end
        RSCI_CMD_QUERY_DIALECT: begin // [RULE_20]
          ans[0]  <= RSCI_ZERO + 8'(dialect);
          ans_len <= 4'd1;
        end
        default: busy <= 1'b0;
      endcase
    end else if (busy && txb.ready) begin
      if (ans_idx == ans_len - 1'b1 + (term_sel ? 4'd2 : 4'd0)) busy <= 1'b0;
      ans_idx <= ans_idx + 1'b1;
    end
  end

  // Terminator appended per setting [RULE_16]
  always_comb begin
    txb.valid = busy;
    txb.last  = ans_idx == ans_len - 1'b1 + (term_sel ? 4'd2 : 4'd0);
    if (ans_idx < ans_len) txb.data = ans[ans_idx[2:0]];
    else if (ans_idx == ans_len) txb.data = RSCI_CR;
    else txb.data = RSCI_LF;
  end

  rsci_tx_buffer #(.DEPTH(DEPTH)) u_tx (
    .clk      (clk),
    .resetn   (resetn),
    .flush    (clr),
    .wr       (txb),
    .tx_valid (tx_valid),
    .tx_data  (tx_data),
    .tx_eoi   (tx_eoi),
    .tx_ready (tx_ready)
  );
endmodule // rsci_top

// ===== dv/rsci_top_asserts.sv
// Port checker of the remote status and command intake block.
// Assumes it is bound to rsci_top; one clock domain.
module rsci_top_asserts
  import rsci_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Stimulus seen at the ports
  input  wire logic       dev_clear,
  input  wire logic       cmd_valid,
  input  wire rsci_cmd_e  cmd_code,
  input  wire logic       ev_output_set_done,
  input  wire logic       sweep_active,
  input  wire logic       tx_ready,
  // Results
  input  wire logic       code_valid,
  input  wire logic [7:0] code_char,
  input  wire logic       code_end,
  input  wire logic       msg_end,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       srq,
  input  wire logic [7:0] status_byte,
  input  wire logic [7:0] service_request_enable_mask
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic       mask_wr;
  logic [7:0] causes;
  assign mask_wr = cmd_valid && cmd_code == RSCI_CMD_SET_MASK;
  // Bit 6 mask has no effect, so leave it out of the cause set
  assign causes  = service_request_enable_mask & 8'hBF;
  // ****************
  // Assertions
  // ****************
  zero_bits_a: assert property (
    (status_byte & RSCI_ZERO_BITS) == 8'h00) else $error("fixed bit set");
  srq_bit6_a: assert property (
    srq |-> status_byte[6]) else $error("srq without bit 6");
  mask_clear_a: assert property (
    mask_wr |=> status_byte == 8'h00 && !srq) else $error("no clear");
  cause_sets_a: assert property (
    ev_output_set_done && service_request_enable_mask[0] && !mask_wr
    |=> status_byte[0] && status_byte[6] ##[0:1] srq)
    else $error("enabled cause lost");
  masked_srq_a: assert property (
    causes == 8'h00 && !mask_wr |=> !$rose(srq))
    else $error("request from disabled cause");
  code_space_a: assert property (
    code_valid |-> code_char != RSCI_SPACE && code_char != RSCI_COMMA)
    else $error("delimiter passed as code");
  msg_end_a: assert property (
    msg_end |-> code_end) else $error("message end without code end");
  sweep_lock_a: assert property (
    sweep_active [*8] |-> !code_valid) else $error("code during sweep");
  tx_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("talker byte dropped");
  dev_clear_a: assert property (
    dev_clear [*6] |-> !srq && !tx_valid) else $error("clear ignored");
  cover property (mask_wr);
  cover property (msg_end);
  cover property ($rose(srq));
endmodule // rsci_top_asserts

bind rsci_top rsci_top_asserts i_rsci_top_asserts (
  .clk, .resetn, .dev_clear, .cmd_valid, .cmd_code, .ev_output_set_done,
  .sweep_active, .tx_ready, .code_valid, .code_char, .code_end, .msg_end,
  .tx_valid, .tx_data, .srq, .status_byte, .service_request_enable_mask);

// ===== dv/rsci_ctrl_model.sv
// Bus controller model: sends program bytes, takes talker bytes.
// Assumes the intake synchronises the listener lines itself.
module rsci_ctrl_model
  import rsci_pkg::*;
#(
  parameter int CLR_WAIT = 100
) (
  // Clock
  input  wire logic       clk,
  // Listener lines
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_eoi,
  output logic            dev_clear,
  // Talker lines
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_eoi,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got[$];
  logic [2:0] pace = 3'd0;
  initial begin
    rx_valid  = 1'b0;
    rx_data   = 8'h00;
    rx_eoi    = 1'b0;
    dev_clear = 1'b0;
    tx_ready  = 1'b0;
  end
  // Stalls on and off so the talker must hold its byte
  always @(posedge clk) begin
    pace     <= pace + 3'd1;
    tx_ready <= pace[2];
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got.push_back({tx_eoi, tx_data});
  end
  task automatic send_byte(input logic [7:0] b, input logic eoi);
    @(posedge clk);
    rx_data  <= b;
    rx_eoi   <= eoi;
    @(posedge clk);
    rx_valid <= 1'b1;
    repeat (3) @(posedge clk);
    rx_valid <= 1'b0;
    repeat (3) @(posedge clk);
    // Released lines show no stale byte
    rx_data  <= ~b;
    rx_eoi   <= ~eoi;
  endtask
  task automatic send_msg(input string s, input logic eoi);
    foreach (s[i])
      send_byte(8'(s[i]), eoi && i == s.len() - 1);
  endtask
  task automatic clear();
    @(posedge clk);
    dev_clear <= 1'b1;
    repeat (10) @(posedge clk);
    dev_clear <= 1'b0;
    repeat (CLR_WAIT) @(posedge clk);
  endtask
endmodule // rsci_ctrl_model

// ===== dv/test_rsci_top.sv
// Self-checking bench of the remote status and command intake.
// Assumes the controller model owns the bus lines; bench owns the rest.
module test_rsci_top
  import rsci_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk = 1'b0;
  logic          resetn = 1'b0;
  logic          cv_r = 1'b0;
  logic          arm = 1'b0;
  rsci_cmd_e     cc_r = RSCI_CMD_NONE;
  logic [1:0]    cmd_arg = 2'd0;
  logic [6:0]    evs = 7'h00;
  logic          error_active = 1'b0;
  logic          sweep_active = 1'b0;
  logic          rx_valid, rx_eoi, dev_clear, tx_ready, cmd_valid;
  logic          tx_valid, tx_eoi, code_valid, code_end, msg_end;
  logic          code_refused, srq, native_strict, code_digit;
  logic [7:0]    rx_data, tx_data, code_char, status_byte, mask;
  logic [19:0]   code_number;
  rsci_cmd_e     cmd_code;
  rsci_dialect_e dialect;
  int            n_errors = 0, n_tests = 0, n_msg = 0, n_ref = 0;
  string         chars = "";
  logic [19:0]   nums[$];

  // Mask write must meet the code end in its own cycle
  assign cmd_valid = cv_r | (arm & code_end);
  assign cmd_code  = (arm & code_end) ? RSCI_CMD_SET_MASK : cc_r;
  always #4 clk = ~clk;

  rsci_top #(.DEPTH(16)) i_rsci_top (
    .clk, .resetn, .rx_valid, .rx_data, .rx_eoi, .dev_clear,
    .cmd_valid, .cmd_code, .cmd_arg,
    .ev_output_set_done(evs[0]), .ev_wavelength_set_done(evs[1]),
    .ev_sweep_end(evs[2]), .ev_program_end(evs[3]),
    .ev_standby_done(evs[4]), .ev_init_done(evs[5]),
    .ev_calib_done(evs[6]), .error_active, .sweep_active,
    .code_valid, .code_char, .code_end, .code_digit, .code_number,
    .msg_end, .code_refused, .tx_valid, .tx_data, .tx_eoi, .tx_ready,
    .srq, .status_byte, .service_request_enable_mask(mask), .dialect,
    .native_strict);
  rsci_ctrl_model i_rsci_ctrl_model (
    .clk, .rx_valid, .rx_data, .rx_eoi, .dev_clear,
    .tx_valid, .tx_data, .tx_eoi, .tx_ready);

  always @(posedge clk) begin
    if (code_valid === 1'b1)
      chars = {chars, string'(code_char)};
    if (code_valid === 1'b1)
      chk(code_digit, 20'(code_char inside {[8'h30:8'h39]}));
    if (code_end === 1'b1)
      nums.push_back(code_number);
    if (msg_end === 1'b1)
      n_msg++;
    if (code_refused === 1'b1)
      n_ref++;
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t value %0h not %0h", $time, got, exp);
    end
  endtask
  task automatic chk_s(input string got, input string exp);
    n_tests++;
    if (got != exp) begin
      n_errors++;
      $display("MISMATCH %0t codes %s not %s", $time, got, exp);
    end
  endtask
  task automatic expect_tx(input string s);
    logic [8:0] g[$];
    repeat (80) @(posedge clk);
    g = i_rsci_ctrl_model.got;
    i_rsci_ctrl_model.got.delete();
    chk(20'(g.size()), 20'(s.len()));
    foreach (s[i]) begin
      chk(20'(g[i][7:0]), 20'(s[i]));
      chk(20'(g[i][8]), 20'(i == s.len() - 1));
    end
  endtask
  task automatic cmd(input rsci_cmd_e c, input logic [1:0] a);
    @(posedge clk);
    cv_r    <= 1'b1;
    cc_r    <= c;
    cmd_arg <= a;
    @(posedge clk);
    cv_r    <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic ev(input logic [6:0] v);
    @(posedge clk);
    evs <= v;
    @(posedge clk);
    evs <= 7'h00;
    repeat (4) @(posedge clk);
  endtask
  task automatic set_mask(input string n);
    arm <= 1'b1;
    i_rsci_ctrl_model.send_msg({"I", n, "\n"}, 1'b1);
    repeat (8) @(posedge clk);
    arm <= 1'b0;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    chk(status_byte, RSCI_STB_RESET);
    chk(mask, RSCI_MASK_RESET);
    chk(srq, 1'b0);
    chk(dialect, RSCI_DIALECT_NATIVE);
    chk(native_strict, 1'b1);
  endtask
  task automatic t_parse();
    i_rsci_ctrl_model.send_msg("I 6 5,X1.5\r\n", 1'b0);
    i_rsci_ctrl_model.send_msg("X7\n", 1'b1);
    repeat (8) @(posedge clk);
    chk_s(chars, "I65X15X7");
    chk(20'(nums.size()), 20'd3);
    chk(nums[0], 20'd65000);
    chk(nums[1], 20'd1500);
    chk(20'(n_msg), 20'd2);
  endtask
  task automatic t_setdone();
    set_mask("65");
    chk(mask, 8'h41);
    ev(7'h01);
    chk(status_byte, 8'h41);
    chk(srq, 1'b1);
    ev(7'h04);
    chk(status_byte, 8'h41);
    cmd(RSCI_CMD_QUERY_STATUS_BYTE, 2'd0);
    expect_tx("065\r\n");
    cmd(RSCI_CMD_QUERY_SETTING_DONE, 2'd0);
    expect_tx("10\r\n");
    set_mask("66");
    chk(status_byte, 8'h00);
    chk(srq, 1'b0);
  endtask
  task automatic t_opdone();
    cmd(RSCI_CMD_SET_TERMINATOR, 2'd0);
    set_mask("8");
    ev(7'h20);
    chk(status_byte, 8'h48);
    cmd(RSCI_CMD_QUERY_OPERATION_DONE, 2'd0);
    expect_tx("00010");
    cmd(RSCI_CMD_QUERY_MASK, 2'd0);
    expect_tx("008");
    set_mask("0");
    ev(7'h7F);
    chk(status_byte, 8'h00);
    chk(srq, 1'b0);
  endtask
  task automatic t_error();
    set_mask("4");
    error_active <= 1'b1;
    repeat (4) @(posedge clk);
    chk(status_byte, 8'h44);
    error_active <= 1'b0;
    i_rsci_ctrl_model.clear();
    chk(srq, 1'b0);
  endtask
  task automatic t_dialect();
    string e = "0";
    for (int d = 0; d < 3; d++) begin
      cmd(RSCI_CMD_SELECT_DIALECT, 2'(d));
      chk(dialect, 20'(d));
      chk(native_strict, 20'(d == 0));
      cmd(RSCI_CMD_QUERY_DIALECT, 2'd0);
      e[0] = 8'(RSCI_ZERO + d);
      expect_tx(e);
    end
  endtask
  task automatic t_sweep();
    chars = "";
    sweep_active <= 1'b1;
    repeat (8) @(posedge clk);
    i_rsci_ctrl_model.send_byte(8'h41, 1'b1);
    repeat (8) @(posedge clk);
    chk(20'(n_ref), 20'd1);
    chk_s(chars, "");
    sweep_active <= 1'b0;
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_parse();
    chars = "";
    t_setdone();
    t_opdone();
    t_error();
    t_dialect();
    t_sweep();
    print_verdict();
  end
  // Whole run needs well under this many cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule // test_rsci_top
